// ### src/fault_status_latch.sv
// Sticky fault status bank with side-gated clears and Avalon-MM access
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`default_nettype none
// Overview of operation
// - A status clear is accepted only from the side that holds control; the other is refused and flagged in interrupt status.
// - An accepted clear drops only the controlling side's alert, never the other side's.
// - Redundancy diode test pass or fail stays latched until a clear-faults command.
// - Shutdown is latched whenever the main output is off and held until cleared.
// - Voltage, current, fan, input, unknown, comm, internal and external flags all latch.
// - Current and temperature response settings change only on an explicit write.
// - A fault still present after a clear sets its flag again.
// - Operational state bits follow the present condition and are never latched.
module fault_status_latch (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [fsl_pkg::FSL_NCOND-1:0] cond_pin,
  input wire logic output_on_pin,
  input wire logic control_side,
  input wire logic clear_req_a,
  input wire logic clear_req_b,
  input wire logic comm_err,
  input wire logic oring_done,
  input wire logic oring_pass,
  output logic alert_a,
  output logic alert_b,
  output logic irq,
  output logic [7:0] excess_current_resp,
  output logic [7:0] excess_temperature_resp
);
  import fsl_pkg::*;

  logic [FSL_NCOND-1:0] cond_s;
  logic out_on_s;
  fsl_bus_e bus_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [FSL_FAULT_W-1:0] fault_q;
  logic [FSL_FAULT_W-1:0] fault_set;
  logic [FSL_FAULT_W-1:0] fault_d;
  logic [7:0] curr_resp_q;
  logic [7:0] temp_resp_q;
  logic [FSL_IRQ_W-1:0] irq_stat_q;
  logic [FSL_IRQ_W-1:0] irq_mask_q;
  logic [FSL_IRQ_W-1:0] irq_evt;
  logic irq_q;
  logic alert_a_q;
  logic alert_b_q;
  logic rd_take;
  logic wr_ok;
  logic bus_clr;
  logic clr_a;
  logic clr_b;
  logic clear_ok;
  logic clear_bad;
  logic new_evt;
  logic [31:0] live_word;
  logic [31:0] rd_mux;
  logic [FSL_NCOND:0] sync_lvl;
  logic [31:0] curr_m;
  logic [31:0] temp_m;
  logic [31:0] mask_m;

  // Merge write data into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic wr_hit(input logic [7:0] a);
    return wr_ok && (avs_address == a);
  endfunction

  fsl_in_sync #(
    .W(FSL_NCOND + 1)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin({output_on_pin, cond_pin}),
    .level(sync_lvl)
  );

  assign out_on_s = sync_lvl[FSL_NCOND];
  assign cond_s = sync_lvl[FSL_NCOND-1:0];

  // Bus slave: one wait state, then a single-cycle acknowledge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_q <= FSL_BUS_IDLE;
      wait_q <= 1'b1;
    end else begin
      case (bus_q)
        FSL_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= FSL_BUS_ACK;
            wait_q <= 1'b0;
          end
        end
        FSL_BUS_ACK: begin
          bus_q <= FSL_BUS_IDLE;
          wait_q <= 1'b1;
        end
        default: begin
          bus_q <= FSL_BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  assign rd_take = avs_read && (bus_q == FSL_BUS_IDLE);
  assign wr_ok = avs_write && (bus_q == FSL_BUS_ACK);

  // Live view carries no latch at all
  always_comb begin
    live_word = FSL_ZERO32;
    live_word[FSL_LIVE_ON] = out_on_s;
    live_word[FSL_LIVE_SIDE] = control_side;
    live_word[FSL_LIVE_ANY] = |cond_s;
    live_word[FSL_LIVE_COND +: FSL_NCOND] = cond_s;
  end

  // Unmapped and write-only addresses read as zero
  always_comb begin
    rd_mux = FSL_ZERO32;
    case (avs_address)
      FSL_ADDR_FAULT: rd_mux[FSL_FAULT_W-1:0] = fault_q;
      FSL_ADDR_LIVE: rd_mux = live_word;
      FSL_ADDR_CURR_RESP: rd_mux[7:0] = curr_resp_q;
      FSL_ADDR_TEMP_RESP: rd_mux[7:0] = temp_resp_q;
      FSL_ADDR_IRQ_STAT: rd_mux[FSL_IRQ_W-1:0] = irq_stat_q;
      FSL_ADDR_IRQ_MASK: rd_mux[FSL_IRQ_W-1:0] = irq_mask_q;
      FSL_ADDR_ALERT: rd_mux[1:0] = {alert_b_q, alert_a_q};
      default: rd_mux = FSL_ZERO32;
    endcase
  end

  // Read data is captured as waitrequest drops, so it stands at the ack edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= FSL_ZERO32;
    end else if (rd_take) begin
      rdata_q <= rd_mux;
    end
  end

  // Clear sources: either side's request line or a bus command naming a side
  assign bus_clr = wr_ok && (avs_address == FSL_ADDR_CLEAR) && avs_byteenable[0];
  assign clr_a = clear_req_a || (bus_clr && !avs_writedata[FSL_CLR_SIDE]);
  assign clr_b = clear_req_b || (bus_clr && avs_writedata[FSL_CLR_SIDE]);
  assign clear_ok = (clr_a && !control_side) || (clr_b && control_side);
  assign clear_bad = (clr_a && control_side) || (clr_b && !control_side);

  // Conditions are levels, so a persisting one keeps setting its flag
  always_comb begin
    fault_set = '0;
    fault_set[FSL_NCOND-1:0] = cond_s;
    fault_set[FSL_BIT_COMM] = comm_err;
    fault_set[FSL_BIT_SHUT] = !out_on_s;
    fault_set[FSL_BIT_PASS] = oring_done && oring_pass;
    fault_set[FSL_BIT_FAIL] = oring_done && !oring_pass;
  end

  // Set wins over clear
  assign fault_d = (fault_q & ~{FSL_FAULT_W{clear_ok}}) | fault_set;
  assign new_evt = |(fault_set & ~fault_q);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_q <= '0;
    end else begin
      fault_q <= fault_d;
    end
  end

  // Each side keeps its own alert; only its own accepted clear drops it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alert_a_q <= 1'b0;
      alert_b_q <= 1'b0;
    end else begin
      alert_a_q <= (alert_a_q && !(clear_ok && !control_side)) || new_evt;
      alert_b_q <= (alert_b_q && !(clear_ok && control_side)) || new_evt;
    end
  end

  // Lane merge kept outside the flops; a select on a call result is not portable
  assign curr_m = be_merge({24'h00_0000, curr_resp_q}, avs_writedata, avs_byteenable);
  assign temp_m = be_merge({24'h00_0000, temp_resp_q}, avs_writedata, avs_byteenable);
  assign mask_m = be_merge({29'h0000_0000, irq_mask_q}, avs_writedata, avs_byteenable);

  // Response settings see no path from any clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      curr_resp_q <= FSL_RESP_RST;
      temp_resp_q <= FSL_RESP_RST;
    end else begin
      if (wr_hit(FSL_ADDR_CURR_RESP)) begin
        curr_resp_q <= curr_m[7:0];
      end
      if (wr_hit(FSL_ADDR_TEMP_RESP)) begin
        temp_resp_q <= temp_m[7:0];
      end
    end
  end

  // Interrupt events: new latch, clear accepted, clear refused
  always_comb begin
    irq_evt = '0;
    irq_evt[FSL_IRQ_NEW] = new_evt;
    irq_evt[FSL_IRQ_CLR_OK] = clear_ok;
    irq_evt[FSL_IRQ_CLR_BAD] = clear_bad;
  end

  // Write-one-to-clear; a new event in the same cycle survives
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      if (wr_hit(FSL_ADDR_IRQ_STAT) && avs_byteenable[0]) begin
        irq_stat_q <= (irq_stat_q & ~avs_writedata[FSL_IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_q <= irq_stat_q | irq_evt;
      end
      if (wr_hit(FSL_ADDR_IRQ_MASK)) begin
        irq_mask_q <= mask_m[FSL_IRQ_W-1:0];
      end
    end
  end

  // Registered output costs one cycle of interrupt latency
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign alert_a = alert_a_q;
  assign alert_b = alert_b_q;
  assign irq = irq_q;
  assign excess_current_resp = curr_resp_q;
  assign excess_temperature_resp = temp_resp_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Clear from side B alone while side A holds control never drops a latched bit
  side_gate_a: assert property ((clr_b && !control_side && !clr_a)
    |=> &(fault_q | ~$past(fault_q)))
    else $error("clear from non-controlling side altered status");

  clear_drops_a: assert property ((clear_ok && fault_set == '0)
    |=> fault_q == '0)
    else $error("accepted clear did not drop status");

  other_alert_a: assert property ((clear_ok && !control_side && alert_b_q)
    |=> alert_b_q)
    else $error("controlling clear dropped the other side alert");

  oring_hold_a: assert property ((oring_done && oring_pass)
    |=> fault_q[FSL_BIT_PASS] ##1 (fault_q[FSL_BIT_PASS] || $past(clear_ok)))
    else $error("diode test result not held");

  shutdown_latch_a: assert property ((!out_on_s)
    |=> fault_q[FSL_BIT_SHUT])
    else $error("shutdown not latched while output off");

  cond_latch_a: assert property (1'b1
    |=> (fault_q[FSL_NCOND-1:0] & $past(cond_s)) == $past(cond_s))
    else $error("present condition not latched");

  resp_stable_a: assert property ((!(wr_ok && avs_address == FSL_ADDR_CURR_RESP))
    |=> $stable(curr_resp_q) && excess_current_resp == curr_resp_q)
    else $error("current response changed without a write");

  reassert_a: assert property ((clear_ok && cond_s[0]) ##1 cond_s[0]
    |=> fault_q[0])
    else $error("persisting fault did not reassert");

  live_read_a: assert property ((rd_take && avs_address == FSL_ADDR_LIVE)
    |=> avs_readdata[FSL_LIVE_ON] == $past(out_on_s) && !avs_waitrequest)
    else $error("live read does not show current output state");

  set_wins_a: assert property ((clear_ok && comm_err)
    |=> fault_q[FSL_BIT_COMM])
    else $error("event lost to a same-cycle clear");

  irq_level_a: assert property (((irq_stat_q & irq_mask_q) != '0) |=> irq)
    else $error("unmasked status without interrupt");

  irq_low_a: assert property (((irq_stat_q & irq_mask_q) == '0) |=> !irq)
    else $error("interrupt without unmasked status");

  fault_hold_a: assert property ((!clear_ok)
    |=> &(fault_q | ~$past(fault_q)))
    else $error("latched bit dropped without accepted clear");

  fail_latch_a: assert property ((oring_done && !oring_pass)
    |=> fault_q[FSL_BIT_FAIL])
    else $error("diode test failure not latched");

  temp_stable_a: assert property ((!(wr_ok && avs_address == FSL_ADDR_TEMP_RESP))
    |=> $stable(temp_resp_q))
    else $error("temperature response changed without a write");

  live_cond_a: assert property ((rd_take && avs_address == FSL_ADDR_LIVE)
    |=> avs_readdata[FSL_LIVE_COND +: FSL_NCOND] == $past(cond_s))
    else $error("live read does not show present conditions");

  alert_set_a: assert property (new_evt
    |=> alert_a_q && alert_b_q)
    else $error("new fault did not raise both alerts");

  clear_refused_a: assert property (clear_bad
    |=> irq_stat_q[FSL_IRQ_CLR_BAD])
    else $error("refused clear not reported");

  bus_ack_a: assert property ((bus_q == FSL_BUS_IDLE && (avs_read || avs_write))
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus acknowledge not one wait state and one cycle");

  cover_clear_ok_c: cover property (clear_ok ##1 fault_q == '0);
  cover_clear_bad_c: cover property (clear_bad ##1 irq_stat_q[FSL_IRQ_CLR_BAD]);
  cover_reassert_c: cover property (clear_ok && cond_s[1] ##1 fault_q[1]);
  cover_irq_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// ### src/fsl_pkg.sv
// Constants shared by the fault status latch design files
`default_nettype none
package fsl_pkg;
  // Register byte addresses
  localparam logic [7:0] FSL_ADDR_FAULT = 8'h00;
  localparam logic [7:0] FSL_ADDR_LIVE = 8'h04;
  localparam logic [7:0] FSL_ADDR_CLEAR = 8'h08;
  localparam logic [7:0] FSL_ADDR_CURR_RESP = 8'h0c;
  localparam logic [7:0] FSL_ADDR_TEMP_RESP = 8'h10;
  localparam logic [7:0] FSL_ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] FSL_ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] FSL_ADDR_ALERT = 8'h1c;

  // Fault condition pins, in status bit order
  localparam int FSL_NCOND = 14;
  localparam int FSL_FAULT_W = 18;
  localparam int FSL_BIT_COMM = 14;
  localparam int FSL_BIT_SHUT = 15;
  localparam int FSL_BIT_PASS = 16;
  localparam int FSL_BIT_FAIL = 17;

  // Live status fields
  localparam int FSL_LIVE_ON = 0;
  localparam int FSL_LIVE_SIDE = 1;
  localparam int FSL_LIVE_ANY = 2;
  localparam int FSL_LIVE_COND = 16;

  // Clear command: side that issues it
  localparam int FSL_CLR_SIDE = 0;

  // Interrupt status fields
  localparam int FSL_IRQ_W = 3;
  localparam int FSL_IRQ_NEW = 0;
  localparam int FSL_IRQ_CLR_OK = 1;
  localparam int FSL_IRQ_CLR_BAD = 2;

  // Reset values
  localparam logic [7:0] FSL_RESP_RST = 8'h00;
  localparam logic [31:0] FSL_ZERO32 = 32'h0000_0000;
  localparam logic [2:0] FSL_SYNC_RST = 3'h0;

  typedef enum logic [1:0] {
    FSL_BUS_IDLE = 2'b01,
    FSL_BUS_ACK = 2'b10
  } fsl_bus_e;
endpackage
`default_nettype wire

// ### src/fsl_in_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module fsl_in_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  import fsl_pkg::*;

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  // First stage feeds only the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign level = level_q;
endmodule
`default_nettype wire

// ### testbench/fsl_host_model.sv
// Host controller model on the two management bus sides
`default_nettype none
module fsl_host_model (
  input wire logic core_clk,
  output logic control_side,
  output logic clear_req_a,
  output logic clear_req_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    control_side = 1'b0;
    clear_req_a = 1'b0;
    clear_req_b = 1'b0;
  end
  // One-cycle clear-faults from one side; acknowledges latched results
  task automatic clear(input logic side);
    @(posedge core_clk);
    if (side) begin
      clear_req_b <= 1'b1;
    end else begin
      clear_req_a <= 1'b1;
    end
    @(posedge core_clk);
    clear_req_a <= 1'b0;
    clear_req_b <= 1'b0;
  endtask
  // Control hand-over, decided elsewhere
  task automatic take(input logic side);
    @(posedge core_clk);
    control_side <= side;
  endtask
endmodule
`default_nettype wire

// ### testbench/fault_status_latch_test.sv
// Self-checking bench for the fault status latch
`default_nettype none
module fault_status_latch_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fsl_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [13:0] cond_pin = 14'h0000;
  logic output_on_pin = 1'b1;
  logic control_side, clear_req_a, clear_req_b;
  logic comm_err = 1'b0;
  logic oring_done = 1'b0;
  logic oring_pass = 1'b0;
  logic alert_a, alert_b, irq;
  logic [7:0] excess_current_resp, excess_temperature_resp;
  logic [31:0] exp_f, q;
  logic [7:0] r1, r2;
  logic [13:0] c;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 32'h18908f56;
  always #5 core_clk = ~core_clk;
  fsl_host_model host (.core_clk(core_clk), .control_side(control_side),
    .clear_req_a(clear_req_a), .clear_req_b(clear_req_b));
  fault_status_latch dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cond_pin(cond_pin), .output_on_pin(output_on_pin),
    .control_side(control_side), .clear_req_a(clear_req_a), .clear_req_b(clear_req_b),
    .comm_err(comm_err), .oring_done(oring_done), .oring_pass(oring_pass),
    .alert_a(alert_a), .alert_b(alert_b), .irq(irq),
    .excess_current_resp(excess_current_resp),
    .excess_temperature_resp(excess_temperature_resp));
  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // Only the watchdog ends a wait that never answers
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] t;
    bus(1'b0, a, 32'h0000_0000, t);
    chk(t, e);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  initial begin
    #200000;
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    wait_n(3);
    rst <= 1'b0;
    wait_n(10);
    exp_f = 32'h0000_8000;
    rdchk(FSL_ADDR_FAULT, exp_f);
    rdchk(FSL_ADDR_CURR_RESP, 32'h0000_0000);
    r1 = $random(seed);
    r2 = $random(seed);
    wr(FSL_ADDR_CURR_RESP, {24'h0, r1});
    wr(FSL_ADDR_TEMP_RESP, {24'h0, r2});
    wr(FSL_ADDR_IRQ_MASK, 32'h0000_0007);
    host.clear(1'b0);
    wait_n(3);
    wr(FSL_ADDR_IRQ_STAT, 32'h0000_0007);
    exp_f = 32'h0000_0000;
    rdchk(FSL_ADDR_FAULT, exp_f);
    rdchk(FSL_ADDR_TEMP_RESP, {24'h0, r2});
    chk({24'h0, excess_current_resp}, {24'h0, r1});
    chk({30'h0, alert_b, alert_a}, 32'h0000_0002);
    rdchk(FSL_ADDR_ALERT, 32'h0000_0002);
    c = $random(seed) | 14'h0001;
    cond_pin <= c;
    wait_n(10);
    rdchk(FSL_ADDR_LIVE, {2'b00, c, 13'h0, 3'b101});
    cond_pin <= 14'h0001;
    wait_n(10);
    rdchk(FSL_ADDR_LIVE, {2'b00, 14'h0001, 13'h0, 3'b101});
    exp_f = {18'h0, c};
    rdchk(FSL_ADDR_FAULT, exp_f);
    comm_err <= 1'b1;
    oring_done <= 1'b1;
    oring_pass <= 1'b1;
    output_on_pin <= 1'b0;
    wait_n(1);
    comm_err <= 1'b0;
    oring_done <= 1'b0;
    wait_n(10);
    output_on_pin <= 1'b1;
    wait_n(10);
    exp_f = exp_f | 32'h0001_c000;
    rdchk(FSL_ADDR_FAULT, exp_f);
    chk({31'h0, irq}, 32'h0000_0001);
    host.clear(1'b1);
    wait_n(3);
    rdchk(FSL_ADDR_FAULT, exp_f);
    rdchk(FSL_ADDR_IRQ_STAT, 32'h0000_0005);
    fork
      host.clear(1'b0);
      begin
        @(posedge core_clk);
        comm_err <= 1'b1;
        @(posedge core_clk);
        comm_err <= 1'b0;
      end
    join
    wait_n(10);
    exp_f = 32'h0000_4001;
    rdchk(FSL_ADDR_FAULT, exp_f);
    chk({31'h0, alert_b}, 32'h0000_0001);
    cond_pin <= 14'h0000;
    host.take(1'b1);
    wait_n(10);
    wr(FSL_ADDR_CLEAR, 32'h0000_0001);
    wait_n(3);
    rdchk(FSL_ADDR_FAULT, 32'h0000_0000);
    rdchk(FSL_ADDR_CURR_RESP, {24'h0, r1});
    chk({24'h0, excess_temperature_resp}, {24'h0, r2});
    oring_done <= 1'b1;
    oring_pass <= 1'b0;
    wait_n(1);
    oring_done <= 1'b0;
    wait_n(20);
    rdchk(FSL_ADDR_FAULT, 32'h0002_0000);
    host.clear(1'b1);
    wait_n(3);
    rdchk(FSL_ADDR_FAULT, 32'h0000_0000);
    rdchk(8'h20, 32'h0000_0000);
    wr(FSL_ADDR_IRQ_STAT, 32'h0000_0007);
    wait_n(3);
    chk({31'h0, irq}, 32'h0000_0000);
    end_sim();
  end
endmodule
`default_nettype wire
